// >>> src/riu_pkg.sv
// Purpose: Shared constants and types for the reader interrupt request unit.
// Assumes: APB slave with 32-bit data; each register index n sits at byte address 4*n.
// Notes: Request and enable registers share one bit layout.
package riu_pkg;
  // Register indices; the byte address is four times the index.
  localparam logic [5:0] RIU_IDX_PRIMARY_STATUS = 6'h03;
  localparam logic [5:0] RIU_IDX_SECONDARY_STATUS = 6'h05;
  localparam logic [5:0] RIU_IDX_ENABLE_MASK = 6'h06;
  localparam logic [5:0] RIU_IDX_REQUEST_FLAGS = 6'h07;
  localparam logic [5:0] RIU_IDX_CONTROL = 6'h09;
  localparam logic [5:0] RIU_IDX_TIMER_VALUE = 6'h0c;
  localparam logic [5:0] RIU_IDX_FIFO_LEVEL = 6'h29;
  localparam logic [5:0] RIU_IDX_TIMER_CLOCK = 6'h2a;
  localparam logic [5:0] RIU_IDX_TIMER_CONTROL = 6'h2b;
  localparam logic [5:0] RIU_IDX_TIMER_RELOAD = 6'h2c;
  localparam logic [5:0] RIU_IDX_PIN_CONFIG = 6'h2d;
  // Request and enable bit layout.
  localparam int RIU_BIT_SELECTOR = 7;
  localparam int RIU_BIT_RESERVED = 6;
  localparam int RIU_SRC_TIMER = 5;
  localparam int RIU_SRC_TRANSMIT = 4;
  localparam int RIU_SRC_RECEIVE = 3;
  localparam int RIU_SRC_CMD_DONE = 2;
  localparam int RIU_SRC_FIFO_HIGH = 1;
  localparam int RIU_SRC_FIFO_LOW = 0;
  localparam int RIU_NUM_SRC = 6;
  // Status, control and configuration field positions.
  localparam int RIU_PS_IRQ_BIT = 3;
  localparam int RIU_PS_ALMOST_FULL_BIT = 1;
  localparam int RIU_PS_ALMOST_EMPTY_BIT = 0;
  localparam int RIU_SS_RUNNING_BIT = 7;
  localparam int RIU_CTL_START_NOW_BIT = 1;
  localparam int RIU_CTL_STOP_NOW_BIT = 2;
  localparam int RIU_TC_AUTO_RELOAD_BIT = 5;
  localparam int RIU_TCTL_START_TX_BIT = 0;
  localparam int RIU_PIN_INVERT_BIT = 1;
  localparam int RIU_PIN_DRIVE_BIT = 0;
  // FIFO geometry.
  localparam logic [6:0] RIU_FIFO_DEPTH = 7'h40;
  // Reset values.
  localparam logic RIU_RST_INVERT = 1'b1;
  localparam logic RIU_RST_DRIVE = 1'b0;
  localparam logic [5:0] RIU_RST_FLAGS = 6'h00;
  localparam logic [7:0] RIU_RST_BYTE = 8'h00;
  localparam logic [4:0] RIU_RST_PRESCALE = 5'h00;

  typedef struct packed {
    logic start;
    logic stop;
    logic tick;
    logic auto_reload;
    logic [7:0] reload;
  } riu_timer_ctl_t;

  typedef struct packed {
    logic [7:0] value;
    logic running;
    logic expire;
  } riu_timer_stat_t;
endpackage

// >>> src/riu_timer.sv
// Purpose: Down-counter that raises the timer request on expiry.
// Assumes: Control inputs come from logic on the same clock.
// Notes: Expiry pulses expire and either reloads the count or clears it to zero and stops.
`timescale 1ns/100ps
module riu_timer
  import riu_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire riu_timer_ctl_t ctl_in,
  output riu_timer_stat_t stat_out
);
  riu_timer_stat_t st;
  riu_timer_stat_t next_st;

  always_comb
  begin
    next_st = st;
    next_st.expire = 1'b0;
    if (ctl_in.start)
    begin
      next_st.value = ctl_in.reload;
      next_st.running = (ctl_in.reload != 8'h00);
    end
    else if (ctl_in.stop)
    begin
      // A stop raises no request even if the count is at one.
      next_st.running = 1'b0;
    end
    else if (st.running && ctl_in.tick)
    begin
      if (st.value == 8'h01)
      begin
        next_st.expire = 1'b1;
        if (ctl_in.auto_reload)
        begin
          next_st.value = ctl_in.reload;
        end
        else
        begin
          next_st.value = 8'h00;
          next_st.running = 1'b0;
        end
      end
      else if (st.value != 8'h00)
      begin
        next_st.value = st.value - 8'h01;
      end
      else
      begin
        next_st.running = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign stat_out = st;

  a_reload_at_one: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (st.running && ctl_in.tick && !ctl_in.start && !ctl_in.stop && st.value == 8'h01
     && ctl_in.auto_reload) |=> (st.value == $past(ctl_in.reload)) && st.expire)
    else $error("Auto reload did not reload at one.");

  a_stop_at_zero: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (st.running && ctl_in.tick && !ctl_in.start && !ctl_in.stop && st.value == 8'h01
     && !ctl_in.auto_reload) |=> !st.running && st.value == 8'h00 && st.expire)
    else $error("Counter did not stop at zero.");
endmodule

// >>> src/riu_top.sv
// Purpose: Interrupt request unit of a contactless reader with APB register access.
// Assumes: Event inputs are one-cycle pulses or levels from logic on core_clk_in.
// Notes: Timer ticks are derived from core_clk_in by a power-of-two prescaler.
`timescale 1ns/100ps
module riu_top
  import riu_pkg::*;
#(
  parameter int PRESCALE_WIDTH = 21
)
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic tx_eof_event_in,
  input wire logic crc_done_in,
  input wire logic nvm_write_done_in,
  input wire logic rx_end_event_in,
  input wire logic cmd_is_idle_in,
  input wire logic first_tx_bit_event_in,
  input wire logic [6:0] fifo_byte_count_in,
  output logic irq_out,
  output logic irq_oe_n_out
);
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [5:0] request;
    logic [5:0] enable;
    logic pin_polarity_invert;
    logic pin_drive_mode;
    logic [7:0] reload;
    logic [4:0] prescale;
    logic auto_reload;
    logic start_on_first_tx_bit;
    logic [5:0] fifo_threshold;
    logic start_now;
    logic stop_now;
    logic crc_q;
    logic nvm_q;
    logic idle_q;
    logic [PRESCALE_WIDTH-1:0] presc_cnt;
    logic pending;
    logic irq_pin;
    logic irq_oe_n;
  } riu_state_t;

  riu_state_t st;
  riu_state_t next_st;
  riu_timer_ctl_t tmr_ctl;
  riu_timer_stat_t tmr_stat;
  logic fifo_almost_full;
  logic fifo_almost_empty;
  logic [5:0] hw_set;
  logic bus_write;
  logic [5:0] widx;
  logic [PRESCALE_WIDTH-1:0] presc_mask;

  // Applies a selector-style write: selector high sets ones, low clears ones.
  function automatic logic [5:0] riu_set_clear(input logic [5:0] cur, input logic [5:0] hw,
                                               input logic wr, input logic [7:0] data);
    logic [5:0] bits;
    bits = data[5:0];
    riu_set_clear = cur;
    if (wr && data[RIU_BIT_SELECTOR])
    begin
      riu_set_clear = cur | bits;
    end
    else if (wr)
    begin
      riu_set_clear = cur & ~bits;
    end
    // A hardware event in the clearing cycle survives the clear.
    riu_set_clear = riu_set_clear | hw;
  endfunction

  // Read mux; bit 6 and bit 7 of the flag registers always read zero.
  function automatic logic [31:0] riu_read(input riu_state_t s, input logic [5:0] idx,
                                           input riu_timer_stat_t t, input logic afull,
                                           input logic aempty);
    logic [7:0] b;
    b = 8'h00;
    case (idx)
      RIU_IDX_PRIMARY_STATUS:
      begin
        b[RIU_PS_IRQ_BIT] = s.pending;
        b[RIU_PS_ALMOST_FULL_BIT] = afull;
        b[RIU_PS_ALMOST_EMPTY_BIT] = aempty;
      end
      RIU_IDX_SECONDARY_STATUS: b[RIU_SS_RUNNING_BIT] = t.running;
      RIU_IDX_ENABLE_MASK: b[5:0] = s.enable;
      RIU_IDX_REQUEST_FLAGS: b[5:0] = s.request;
      RIU_IDX_TIMER_VALUE: b = t.value;
      RIU_IDX_FIFO_LEVEL: b[5:0] = s.fifo_threshold;
      RIU_IDX_TIMER_CLOCK:
      begin
        b[4:0] = s.prescale;
        b[RIU_TC_AUTO_RELOAD_BIT] = s.auto_reload;
      end
      RIU_IDX_TIMER_CONTROL: b[RIU_TCTL_START_TX_BIT] = s.start_on_first_tx_bit;
      RIU_IDX_TIMER_RELOAD: b = s.reload;
      RIU_IDX_PIN_CONFIG:
      begin
        b[RIU_PIN_INVERT_BIT] = s.pin_polarity_invert;
        b[RIU_PIN_DRIVE_BIT] = s.pin_drive_mode;
      end
      default: b = 8'h00;
    endcase
    riu_read = {24'h000000, b};
  endfunction

  function automatic logic riu_mapped(input logic [5:0] idx);
    case (idx)
      RIU_IDX_PRIMARY_STATUS, RIU_IDX_SECONDARY_STATUS, RIU_IDX_ENABLE_MASK,
      RIU_IDX_REQUEST_FLAGS, RIU_IDX_CONTROL, RIU_IDX_TIMER_VALUE, RIU_IDX_FIFO_LEVEL,
      RIU_IDX_TIMER_CLOCK, RIU_IDX_TIMER_CONTROL, RIU_IDX_TIMER_RELOAD,
      RIU_IDX_PIN_CONFIG: riu_mapped = 1'b1;
      default: riu_mapped = 1'b0;
    endcase
  endfunction

  // The count is at most the FIFO depth, so the free space never underflows.
  assign fifo_almost_full = ({1'b0, RIU_FIFO_DEPTH - fifo_byte_count_in}
                             <= {2'b00, st.fifo_threshold});
  assign fifo_almost_empty = (fifo_byte_count_in <= {1'b0, st.fifo_threshold});

  assign widx = paddr_in[7:2];
  assign bus_write = psel_in && penable_in && st.pready && pwrite_in && !st.pslverr;

  always_comb
  begin
    hw_set = '0;
    hw_set[RIU_SRC_TIMER] = tmr_stat.expire;
    hw_set[RIU_SRC_TRANSMIT] = tx_eof_event_in
                               || (crc_done_in && !st.crc_q)
                               || (nvm_write_done_in && !st.nvm_q);
    hw_set[RIU_SRC_RECEIVE] = rx_end_event_in;
    hw_set[RIU_SRC_CMD_DONE] = cmd_is_idle_in && !st.idle_q;
    hw_set[RIU_SRC_FIFO_HIGH] = fifo_almost_full;
    hw_set[RIU_SRC_FIFO_LOW] = fifo_almost_empty;
  end

  // A prescale of p gives one timer tick every 2^p core clocks; any p above PRESCALE_WIDTH gives 2^PRESCALE_WIDTH.
  assign presc_mask = PRESCALE_WIDTH'((PRESCALE_WIDTH + 1)'(1) << st.prescale) -
                      PRESCALE_WIDTH'(1);

  always_comb
  begin
    tmr_ctl.start = st.start_now || (first_tx_bit_event_in && st.start_on_first_tx_bit);
    tmr_ctl.stop = st.stop_now;
    tmr_ctl.tick = ((st.presc_cnt & presc_mask) == '0);
    tmr_ctl.auto_reload = st.auto_reload;
    tmr_ctl.reload = st.reload;
  end

  // Timer expiry feeds only the request flag; the value and running outputs reach only the read mux.
  riu_timer u_timer
  (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .ctl_in(tmr_ctl),
    .stat_out(tmr_stat)
  );

  always_comb
  begin
    next_st = st;
    next_st.crc_q = crc_done_in;
    next_st.nvm_q = nvm_write_done_in;
    next_st.idle_q = cmd_is_idle_in;
    next_st.presc_cnt = st.presc_cnt + PRESCALE_WIDTH'(1);
    next_st.start_now = 1'b0;
    next_st.stop_now = 1'b0;
    // Zero-wait slave: the setup cycle prepares the answer for the access cycle.
    next_st.pready = psel_in && !penable_in;
    next_st.pslverr = psel_in && !penable_in && !riu_mapped(widx);
    next_st.prdata = '0;
    if (psel_in && !penable_in && !pwrite_in)
    begin
      next_st.prdata = riu_read(st, widx, tmr_stat, fifo_almost_full, fifo_almost_empty);
    end
    next_st.request = riu_set_clear(st.request, hw_set,
                                    bus_write && widx == RIU_IDX_REQUEST_FLAGS,
                                    pwdata_in[7:0]);
    next_st.enable = riu_set_clear(st.enable, 6'h00,
                                   bus_write && widx == RIU_IDX_ENABLE_MASK,
                                   pwdata_in[7:0]);
    if (bus_write)
    begin
      case (widx)
        RIU_IDX_CONTROL:
        begin
          next_st.start_now = pwdata_in[RIU_CTL_START_NOW_BIT];
          next_st.stop_now = pwdata_in[RIU_CTL_STOP_NOW_BIT];
        end
        RIU_IDX_FIFO_LEVEL: next_st.fifo_threshold = pwdata_in[5:0];
        RIU_IDX_TIMER_CLOCK:
        begin
          next_st.prescale = pwdata_in[4:0];
          next_st.auto_reload = pwdata_in[RIU_TC_AUTO_RELOAD_BIT];
        end
        RIU_IDX_TIMER_CONTROL:
          next_st.start_on_first_tx_bit = pwdata_in[RIU_TCTL_START_TX_BIT];
        RIU_IDX_TIMER_RELOAD: next_st.reload = pwdata_in[7:0];
        RIU_IDX_PIN_CONFIG:
        begin
          next_st.pin_polarity_invert = pwdata_in[RIU_PIN_INVERT_BIT];
          next_st.pin_drive_mode = pwdata_in[RIU_PIN_DRIVE_BIT];
        end
        default: next_st.reload = st.reload;
      endcase
    end
    // The pin is computed from the next flag values so it moves with them.
    next_st.pending = |(next_st.request & next_st.enable);
    if (next_st.pin_drive_mode)
    begin
      next_st.irq_pin = next_st.pending ^ next_st.pin_polarity_invert;
      next_st.irq_oe_n = 1'b0;
    end
    else
    begin
      // Open drain only pulls low; a high level is left to the pull-up.
      next_st.irq_pin = 1'b0;
      next_st.irq_oe_n = next_st.pending ^ next_st.pin_polarity_invert;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st <= '0;
      st.request <= RIU_RST_FLAGS;
      st.enable <= RIU_RST_FLAGS;
      st.reload <= RIU_RST_BYTE;
      st.prescale <= RIU_RST_PRESCALE;
      st.pin_polarity_invert <= RIU_RST_INVERT;
      st.pin_drive_mode <= RIU_RST_DRIVE;
      st.irq_oe_n <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign prdata_out = st.prdata;
  assign pready_out = st.pready;
  assign pslverr_out = st.pslverr;
  assign irq_out = st.irq_pin;
  assign irq_oe_n_out = st.irq_oe_n;

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);

  a_summary_or: assert property (st.pending == |(st.request & st.enable))
    else $error("Summary flag differs from enabled requests.");

  a_push_pull_pin: assert property (st.pin_drive_mode |->
    (!irq_oe_n_out && irq_out == (st.pending ^ st.pin_polarity_invert)))
    else $error("Push-pull pin level wrong.");

  a_open_drain_pin: assert property (!st.pin_drive_mode |->
    (!irq_out && irq_oe_n_out == (st.pending ^ st.pin_polarity_invert)))
    else $error("Open-drain pin drives high or wrong level.");

  a_request_set: assert property ((bus_write && widx == RIU_IDX_REQUEST_FLAGS
    && pwdata_in[7]) |=> ((st.request & $past(pwdata_in[5:0])) == $past(pwdata_in[5:0])))
    else $error("Request set write lost a bit.");

  a_request_clear: assert property ((bus_write && widx == RIU_IDX_REQUEST_FLAGS
    && !pwdata_in[7] && hw_set == 6'h00) |=> ((st.request & $past(pwdata_in[5:0])) == 6'h00))
    else $error("Request clear write left a bit set.");

  a_enable_keep: assert property ((bus_write && widx == RIU_IDX_ENABLE_MASK
    && pwdata_in[7]) |=> ((st.enable & ~$past(pwdata_in[5:0])) ==
    ($past(st.enable) & ~$past(pwdata_in[5:0]))))
    else $error("Enable write disturbed an unselected bit.");

  a_fifo_high: assert property (fifo_almost_full |=> st.request[RIU_SRC_FIFO_HIGH])
    else $error("FIFO high request not raised.");

  a_fifo_low: assert property (fifo_almost_empty |=> st.request[RIU_SRC_FIFO_LOW])
    else $error("FIFO low request not raised.");

  a_timer_request: assert property (tmr_stat.expire |=> st.request[RIU_SRC_TIMER])
    else $error("Timer expiry did not raise its request.");

  a_crc_transmit: assert property ($rose(crc_done_in) |=> st.request[RIU_SRC_TRANSMIT])
    else $error("CRC done did not raise transmit request.");

  a_cmd_done: assert property ($rose(cmd_is_idle_in) |=> st.request[RIU_SRC_CMD_DONE])
    else $error("Command done did not raise its request.");

  a_reserved_read: assert property ((psel_in && !penable_in && !pwrite_in &&
    widx == RIU_IDX_REQUEST_FLAGS) |=> prdata_out[7:6] == 2'b00)
    else $error("Reserved request bits read nonzero.");
endmodule

// >>> sim/riu_host_model.sv
// Purpose: Host side of the interrupt pin; resolves the wire level that the host sees.
// Assumes: An external pull-up holds the wire high whenever the pin is released.
// Notes: Holds no state; the bench reads the resolved level and also checks irq and irq_oe_n directly.
`timescale 1ns/100ps
module riu_host_model
(
  input wire logic irq_in,
  input wire logic irq_oe_n_in,
  output logic pin_level_out
);
  // A released open-drain pin never shows the last driven value; the pull-up decides it.
  assign pin_level_out = irq_oe_n_in ? 1'b1 : irq_in;
endmodule

// >>> sim/riu_top_tb_top.sv
// Purpose: Self-checking bench for the interrupt request unit over APB.
// Assumes: The slave may stretch the access phase; prescale 0 gives one tick per clock.
// Notes: FIFO count idles at 32 so the level watchers stay quiet outside their test.
`timescale 1ns/100ps
module riu_top_tb_top;
  import riu_pkg::*;
  typedef struct packed {logic [5:0] idx; logic [7:0] wd; logic [7:0] exp;} riu_row_t;
  logic core_clk_in, rst_in, psel, penable, pwrite, pready, pslverr, irq, irq_oe_n, pin;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [5:0] ev;
  logic [6:0] cnt;
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;
  riu_row_t rows [6] = '{'{6'h06, 8'h81, 8'h01}, '{6'h06, 8'hff, 8'h3f},
    '{6'h06, 8'h01, 8'h3e}, '{6'h07, 8'h84, 8'h04}, '{6'h07, 8'hc0, 8'h04},
    '{6'h07, 8'h3f, 8'h00}};
  int ebit [5] = '{4, 4, 4, 3, 2};
  riu_top #(.PRESCALE_WIDTH(21)) i_dut (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .tx_eof_event_in(ev[0]), .crc_done_in(ev[1]), .nvm_write_done_in(ev[2]),
    .rx_end_event_in(ev[3]), .cmd_is_idle_in(ev[4]), .first_tx_bit_event_in(ev[5]),
    .fifo_byte_count_in(cnt), .irq_out(irq), .irq_oe_n_out(irq_oe_n));
  riu_host_model i_host (.irq_in(irq), .irq_oe_n_in(irq_oe_n), .pin_level_out(pin));

  initial
  begin
    core_clk_in = 1'b0;
    forever #12.5 core_clk_in = ~core_clk_in;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge core_clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fail_count = fail_count + 1;
      complete_run();
    end
  end

  task automatic check_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic check_bit(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask

  // Read data and the error flag are taken at the edge where pready is sampled high.
  // Only the bench timeout ends a wait, so a stuck slave still reaches the verdict.
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge core_clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge core_clk_in);
    check_bit("pready_setup", 1'b0, pready);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk_in);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, idx, d, rd, err);
  endtask

  task automatic rd_chk(input string nm, input logic [5:0] idx, input logic [7:0] e);
    logic [31:0] rd;
    logic err;
    apb(1'b0, idx, 8'h00, rd, err);
    check_word(nm, {24'h000000, e}, rd);
    check_bit("pslverr", 1'b0, err);
  endtask

  task automatic set_cnt(input logic [6:0] c);
    @(posedge core_clk_in);
    cnt <= c;
  endtask

  initial
  begin
    logic [31:0] rd;
    logic err;
    rst_in = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    ev = 6'h00;
    cnt = 7'h20;
    repeat (4) @(posedge core_clk_in);
    rst_in <= 1'b0;
    @(negedge core_clk_in);
    check_bit("irq_oe_n", 1'b1, irq_oe_n);
    rd_chk("pin_config", RIU_IDX_PIN_CONFIG, 8'h02);
    rd_chk("request", RIU_IDX_REQUEST_FLAGS, 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      wr(rows[i].idx, rows[i].wd);
      rd_chk("set_clear", rows[i].idx, rows[i].exp);
    end
    apb(1'b0, 6'h3f, 8'h00, rd, err);
    check_bit("unmapped_err", 1'b1, err);
    check_word("unmapped_data", 32'h00000000, rd);
    for (int e = 0; e < 5; e++)
    begin
      @(posedge core_clk_in);
      ev[e] <= 1'b1;
      @(posedge core_clk_in);
      ev[e] <= 1'b0;
      rd_chk("event_request", RIU_IDX_REQUEST_FLAGS, 8'h01 << ebit[e]);
      wr(RIU_IDX_REQUEST_FLAGS, 8'h3f);
    end
    wr(RIU_IDX_ENABLE_MASK, 8'h3f);
    wr(RIU_IDX_PIN_CONFIG, 8'h01);
    wr(RIU_IDX_ENABLE_MASK, 8'h88);
    wr(RIU_IDX_REQUEST_FLAGS, 8'h90);
    @(negedge core_clk_in);
    check_bit("masked_pin", 1'b0, pin);
    wr(RIU_IDX_REQUEST_FLAGS, 8'h88);
    @(negedge core_clk_in);
    check_bit("pushpull_irq", 1'b1, irq);
    check_bit("pushpull_oe_n", 1'b0, irq_oe_n);
    rd_chk("primary_status", RIU_IDX_PRIMARY_STATUS, 8'h08);
    wr(RIU_IDX_ENABLE_MASK, 8'h08);
    @(negedge core_clk_in);
    check_bit("enable_cleared_irq", 1'b0, irq);
    wr(RIU_IDX_ENABLE_MASK, 8'h88);
    wr(RIU_IDX_REQUEST_FLAGS, 8'h3f);
    @(negedge core_clk_in);
    check_bit("request_cleared_irq", 1'b0, irq);
    wr(RIU_IDX_PIN_CONFIG, 8'h02);
    @(negedge core_clk_in);
    check_bit("od_idle_oe_n", 1'b1, irq_oe_n);
    check_bit("od_idle_pin", 1'b1, pin);
    wr(RIU_IDX_REQUEST_FLAGS, 8'h88);
    @(negedge core_clk_in);
    check_bit("od_active_pin", 1'b0, pin);
    wr(RIU_IDX_REQUEST_FLAGS, 8'h3f);
    wr(RIU_IDX_FIFO_LEVEL, 8'h0a);
    set_cnt(7'h36);
    rd_chk("status_full", RIU_IDX_PRIMARY_STATUS, 8'h02);
    rd_chk("request_full", RIU_IDX_REQUEST_FLAGS, 8'h02);
    set_cnt(7'h35);
    wr(RIU_IDX_REQUEST_FLAGS, 8'h3f);
    rd_chk("request_below_full", RIU_IDX_REQUEST_FLAGS, 8'h00);
    set_cnt(7'h0a);
    rd_chk("status_empty", RIU_IDX_PRIMARY_STATUS, 8'h01);
    rd_chk("request_empty", RIU_IDX_REQUEST_FLAGS, 8'h01);
    set_cnt(7'h0b);
    wr(RIU_IDX_REQUEST_FLAGS, 8'h3f);
    rd_chk("request_above_empty", RIU_IDX_REQUEST_FLAGS, 8'h00);
    set_cnt(7'h20);
    wr(RIU_IDX_TIMER_RELOAD, 8'hff);
    wr(RIU_IDX_TIMER_CLOCK, 8'h00);
    wr(RIU_IDX_CONTROL, 8'h02);
    rd_chk("timer_running", RIU_IDX_SECONDARY_STATUS, 8'h80);
    repeat (300) @(posedge core_clk_in);
    rd_chk("timer_expired", RIU_IDX_REQUEST_FLAGS, 8'h20);
    rd_chk("timer_stopped", RIU_IDX_SECONDARY_STATUS, 8'h00);
    rd_chk("timer_value", RIU_IDX_TIMER_VALUE, 8'h00);
    wr(RIU_IDX_REQUEST_FLAGS, 8'h3f);
    wr(RIU_IDX_TIMER_RELOAD, 8'h10);
    wr(RIU_IDX_TIMER_CLOCK, 8'h20);
    wr(RIU_IDX_CONTROL, 8'h02);
    repeat (40) @(posedge core_clk_in);
    rd_chk("auto_request", RIU_IDX_REQUEST_FLAGS, 8'h20);
    rd_chk("auto_running", RIU_IDX_SECONDARY_STATUS, 8'h80);
    wr(RIU_IDX_CONTROL, 8'h04);
    wr(RIU_IDX_REQUEST_FLAGS, 8'h3f);
    repeat (40) @(posedge core_clk_in);
    rd_chk("stop_no_request", RIU_IDX_REQUEST_FLAGS, 8'h00);
    rd_chk("stop_halted", RIU_IDX_SECONDARY_STATUS, 8'h00);
    wr(RIU_IDX_TIMER_CONTROL, 8'h01);
    wr(RIU_IDX_TIMER_RELOAD, 8'hff);
    @(posedge core_clk_in);
    ev[5] <= 1'b1;
    @(posedge core_clk_in);
    ev[5] <= 1'b0;
    rd_chk("tx_start_running", RIU_IDX_SECONDARY_STATUS, 8'h80);
    wr(RIU_IDX_CONTROL, 8'h04);
    wr(RIU_IDX_PIN_CONFIG, 8'h03);
    @(negedge core_clk_in);
    check_bit("pp_inv_idle_irq", 1'b1, irq);
    wr(RIU_IDX_REQUEST_FLAGS, 8'h88);
    @(negedge core_clk_in);
    check_bit("pp_inv_active_irq", 1'b0, irq);
    // The receive event lands on the same edge as the clearing write; the set must win.
    fork
      wr(RIU_IDX_REQUEST_FLAGS, 8'h3f);
      begin
        repeat (2) @(posedge core_clk_in);
        ev[3] <= 1'b1;
        @(posedge core_clk_in);
        ev[3] <= 1'b0;
      end
    join
    rd_chk("set_beats_clear", RIU_IDX_REQUEST_FLAGS, 8'h08);
    @(posedge core_clk_in);
    rst_in <= 1'b1;
    @(negedge core_clk_in);
    check_bit("reset_oe_n", 1'b1, irq_oe_n);
    repeat (3) @(posedge core_clk_in);
    rst_in <= 1'b0;
    @(negedge core_clk_in);
    check_bit("release_oe_n", 1'b1, irq_oe_n);
    rd_chk("reset_pin_config", RIU_IDX_PIN_CONFIG, 8'h02);
    rd_chk("reset_request", RIU_IDX_REQUEST_FLAGS, 8'h00);
    rd_chk("reset_enable", RIU_IDX_ENABLE_MASK, 8'h00);
    complete_run();
  end
endmodule
